/* File: fdhc_chk.sv */
// Port-level assertions for the head control block
`timescale 1ns/1ps
`default_nettype none
module fdhc_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata_r,
    input wire logic        pready_r,
    input wire logic        pslverr_r,
    input wire logic [3:0]  step_r,
    input wire logic [3:0]  dir_r,
    input wire logic        fdc_int_r
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup cycle of a transfer
    wire rq_s = psel && !penable;
    apb_ready_a: assert property (rq_s |=> pready_r) else $error("no ready");
    ready_once_a: assert property (pready_r |=> !pready_r)
        else $error("ready held");
    unmapped_err_a: assert property (rq_s && paddr > 8'h10 |=> pslverr_r)
        else $error("no slave error");
    cmd_read_zero_a: assert property (rq_s && !pwrite && paddr == 8'h00
        |=> prdata_r == 32'h0) else $error("command reads nonzero");
    head_bit_a: assert property (rq_s && !pwrite && paddr == 8'h0c
        |=> !prdata_r[2]) else $error("head bit set");
    step_width_a: assert property ($rose(step_r[0])
        |-> step_r[0][*8] ##17 step_r[0] ##1 !step_r[0])
        else $error("step width wrong");
    dir_hold_a: assert property (step_r[0] && $past(step_r[0])
        |-> $stable(dir_r[0])) else $error("direction moved in step");
    step_gap_a: assert property ($fell(step_r[0]) |-> !step_r[0][*2])
        else $error("steps too close");
    poll_int_a: assert property ($rose(presetn) |=> fdc_int_r)
        else $error("no poll interrupt");
    cover property ($rose(step_r[0]));
    cover property ($rose(step_r[1]));
    cover property (pslverr_r);
    cover property ($fell(fdc_int_r));
endmodule // fdhc_chk
bind fdhc_top fdhc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .step_r(step_r),
    .dir_r(dir_r), .fdc_int_r(fdc_int_r));
`default_nettype wire

/* File: fdhc_defs.vh */
// Constants shared by the disk head control command block
`ifndef FDHC_DEFS_VH
`define FDHC_DEFS_VH

// Register byte offsets
`define FDHC_OFS_CMD      8'h00
`define FDHC_OFS_SRT      8'h04
`define FDHC_OFS_STATUS   8'h08
`define FDHC_OFS_RESULT   8'h0c
`define FDHC_OFS_IDREG    8'h10

// Command opcodes in CMD[3:0]
`define FDHC_OP_SENSE_DRV 4'h4
`define FDHC_OP_RECAL     4'h7
`define FDHC_OP_SENSE_INT 4'h8
`define FDHC_OP_READ_ID   4'ha
`define FDHC_OP_SEEK      4'hf

// Interrupt codes
`define FDHC_IC_NORMAL    2'b00
`define FDHC_IC_ABNORMAL  2'b01
`define FDHC_IC_INVALID   2'b10
`define FDHC_IC_POLL      2'b11

// Timing: step-rate unit is 1 ms, clock 25 MHz
`define FDHC_CLK_KHZ      25000
`define FDHC_SRT_UNIT_MS  1
`define FDHC_STEP_PW_NS   1000
`define FDHC_CLK_NS       40
`define FDHC_STEP_PW_CYC  6'h19   // 1000 ns pulse at a 40 ns clock
`define FDHC_SRT_SPAN     5'h10
`define FDHC_RECAL_MAX    7'h4f

// Single-density format fields: counts and fill bytes
`define FDHC_GAP4A_CNT    7'h28
`define FDHC_GAP1_CNT     7'h1a
`define FDHC_GAP2_CNT     7'h0b
`define FDHC_SYNC_CNT     7'h06
`define FDHC_GAP_BYTE     8'hff
`define FDHC_SYNC_BYTE    8'h00
`define FDHC_IAM_BYTE     8'hfc
`define FDHC_IDENTIFIER_ADDRESS_MARK_BYTE    8'hfe
`define FDHC_DAM_BYTE     8'hfb
`define FDHC_DDAM_BYTE    8'hf8

`endif

/* File: fdhc_drive_model.sv */
// Behavioural drive mechanisms: head position per drive
`timescale 1ns/1ps
`default_nettype none
module fdhc_drive_model #(
    parameter int H0 = 3,
    parameter int H1 = 100
) (
    input  wire logic       pclk,
    input  wire logic [3:0] step_r,
    input  wire logic [3:0] dir_r,
    output var  logic [3:0] track_zero_n
);
    int         hp [4] = '{H0, H1, 0, 0};
    int         nst [4] = '{0, 0, 0, 0};
    logic [3:0] st_q = 4'h0;
    // each step edge moves the head, stop at the end stop
    always @(posedge pclk) begin
        for (int i = 0; i < 4; i++) begin
            if (step_r[i] && !st_q[i]) begin
                nst[i]++;
                if (dir_r[i])
                    hp[i]++;
                else if (hp[i] > 0)
                    hp[i]--;
            end
        end
        st_q <= step_r;
    end
    // sensor high only with the head on track zero
    always @* begin
        for (int i = 0; i < 4; i++)
            track_zero_n[i] = (hp[i] == 0);
    end
endmodule // fdhc_drive_model
`default_nettype wire

/* File: fdhc_seek.v */
// One drive's head positioning engine: seek and recalibrate
`timescale 1ns/1ps
`default_nettype none
`include "fdhc_defs.vh"

module fdhc_seek (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       tick,
    input  wire       clr,
    input  wire       start,
    input  wire       recal,
    input  wire [7:0] target,
    input  wire [3:0] step_rate_time,
    input  wire       track_zero_n,
    input  wire       ack,
    output reg        step_r,
    output reg        dir_r,
    output reg  [7:0] present_cylinder_r,
    output reg        done_r,
    output reg        seek_end_r,
    output reg        equip_chk_r,
    output reg        busy_r
);
    localparam S_IDLE  = 2'd0;
    localparam S_CHECK = 2'd1;
    localparam S_PULSE = 2'd2;
    localparam S_WAIT  = 2'd3;

    reg [1:0] state_r;
    reg       recal_r;
    reg [7:0] target_r;
    reg [6:0] steps_r;
    reg [4:0] ivl_r;
    reg [5:0] pw_r;

    // Stepping sequence; a done set in CHECK outranks a same-cycle ack
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r            <= S_IDLE;
            recal_r            <= 1'b0;
            target_r           <= 8'h00;
            steps_r            <= 7'h00;
            ivl_r              <= 5'h00;
            pw_r               <= 6'h00;
            step_r             <= 1'b0;
            dir_r              <= 1'b0;
            present_cylinder_r <= 8'h00;
            done_r             <= 1'b0;
            seek_end_r         <= 1'b0;
            equip_chk_r        <= 1'b0;
            busy_r             <= 1'b0;
        end else if (clr) begin
            state_r            <= S_IDLE;
            step_r             <= 1'b0;
            present_cylinder_r <= 8'h00;
            done_r             <= 1'b0;
            seek_end_r         <= 1'b0;
            equip_chk_r        <= 1'b0;
            busy_r             <= 1'b0;
        end else begin
            if (ack) begin
                done_r <= 1'b0;
                busy_r <= 1'b0;
            end
            case (state_r)
                S_IDLE: begin
                    if (start) begin
                        busy_r      <= 1'b1;
                        recal_r     <= recal;
                        target_r    <= target;
                        steps_r     <= 7'h00;
                        seek_end_r  <= 1'b0;
                        equip_chk_r <= 1'b0;
                        state_r     <= S_CHECK;
                        if (recal)
                            present_cylinder_r <= 8'h00;
                    end
                end
                S_CHECK: begin
                    if (recal_r) begin
                        if (track_zero_n) begin
                            seek_end_r <= 1'b1;
                            done_r     <= 1'b1;
                            busy_r     <= 1'b1;
                            state_r    <= S_IDLE;
                        end else if (steps_r == `FDHC_RECAL_MAX) begin
                            seek_end_r  <= 1'b1;
                            equip_chk_r <= 1'b1;
                            done_r      <= 1'b1;
                            busy_r      <= 1'b1;
                            state_r     <= S_IDLE;
                        end else begin
                            dir_r   <= 1'b0;
                            step_r  <= 1'b1;
                            pw_r    <= `FDHC_STEP_PW_CYC;
                            steps_r <= steps_r + 7'h01;
                            state_r <= S_PULSE;
                        end
                    end else if (present_cylinder_r == target_r) begin
                        seek_end_r <= 1'b1;
                        done_r     <= 1'b1;
                        busy_r     <= 1'b1;
                        state_r    <= S_IDLE;
                    end else begin
                        dir_r   <= (present_cylinder_r < target_r);
                        step_r  <= 1'b1;
                        pw_r    <= `FDHC_STEP_PW_CYC;
                        state_r <= S_PULSE;
                        if (present_cylinder_r < target_r)
                            present_cylinder_r <= present_cylinder_r + 8'h01;
                        else
                            present_cylinder_r <= present_cylinder_r - 8'h01;
                    end
                end
                S_PULSE: begin
                    if (pw_r == 6'h01) begin
                        step_r  <= 1'b0;
                        ivl_r   <= `FDHC_SRT_SPAN - {1'b0, step_rate_time};
                        state_r <= S_WAIT;
                    end else begin
                        pw_r <= pw_r - 6'h01;
                    end
                end
                S_WAIT: begin
                    if (tick) begin
                        if (ivl_r == 5'h01)
                            state_r <= S_CHECK;
                        else
                            ivl_r <= ivl_r - 5'h01;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // fdhc_seek

`default_nettype wire

/* File: fdhc_top.v */
// Disk head control commands with APB register access
// Operation
// - Read-id, recal, seek, transfer result and reset poll raise interrupt
// - Read-id captures first good id field
// - No id mark by second index: abnormal
// - Recal clears cylinder, steps out while low
// - Track zero high ends recal with seek-end
// - 79 steps without track zero: equipment check
// - Busy only in command phase, drives overlap
// - Seek direction from present versus target
// - Step-rate spacing, stop on equal cylinder
// - Unsensed drive stays busy
// - Head bit in status zero reads zero
// - Powerdown exit clears cylinder and status
// - Interrupt on result phase and seek end
// - Sense interrupt clears and reports cause
// - Cause encoding seek-end plus interrupt code
// - Sense drive status returns status three
// - Single-density format field sequence
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fdhc_defs.vh"

module fdhc_top #(
    parameter STEP_UNIT_CYC = `FDHC_SRT_UNIT_MS * `FDHC_CLK_KHZ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_r,
    output reg         pready_r,
    output reg         pslverr_r,
    input  wire [3:0]  track_zero_n,
    input  wire        index_pulse_n,
    input  wire        write_prot_n,
    input  wire        id_valid,
    input  wire [31:0] id_field,
    input  wire        xfer_result,
    input  wire        pd_exit,
    input  wire        fmt_start,
    input  wire        fmt_deleted,
    input  wire        fmt_ready,
    output reg  [7:0]  fmt_byte_r,
    output reg         fmt_valid_r,
    output wire [3:0]  step_r,
    output wire [3:0]  dir_r,
    output reg         fdc_int_r
);
    localparam RI_IDLE = 1'b0;
    localparam RI_WAIT = 1'b1;

    // Bus decode: writes act on the access edge; reads are captured in the setup cycle
    wire       acc    = psel & penable & pready_r;
    wire       wr_acc = acc & pwrite;
    wire       cmd_wr = wr_acc & (paddr == `FDHC_OFS_CMD);
    wire [3:0] op     = pwdata[3:0];
    wire [1:0] dsel   = pwdata[5:4];

    reg  [3:0]  srt_r;
    reg  [7:0]  st0_r;
    reg  [7:0]  res_byte_r;
    reg  [31:0] idreg_r;
    reg         ma_r;
    reg         ri_state_r;
    reg  [1:0]  idx_cnt_r;
    reg         idx_prev_r;
    reg         xfer_pend_r;
    reg         poll_pend_r;
    reg         cmd_busy_r;
    reg  [17:0] pre_r;
    reg         tick_r;
    reg  [3:0]  ack_r;
    reg  [1:0]  drive_r;

    wire [3:0]  d_start;
    wire [3:0]  d_done;
    wire [3:0]  d_se;
    wire [3:0]  d_ec;
    wire [3:0]  d_busy;
    wire [31:0] d_pcn;

    // Step-rate prescaler: one enable pulse per unit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r  <= 18'h00000;
            tick_r <= 1'b0;
        end else if (pre_r == STEP_UNIT_CYC[17:0] - 18'h00001) begin
            pre_r  <= 18'h00000;
            tick_r <= 1'b1;
        end else begin
            pre_r  <= pre_r + 18'h00001;
            tick_r <= 1'b0;
        end
    end

    // Seek engines, one per drive, all positioning in parallel
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : drv
            // accept seeks on any idle drive
            assign d_start[g] = cmd_wr & (dsel == g) & ~d_busy[g] &
                                ((op == `FDHC_OP_SEEK) |
                                 (op == `FDHC_OP_RECAL));
            fdhc_seek u_seek (
                .pclk               (pclk),
                .presetn            (presetn),
                .tick               (tick_r),
                .clr                (pd_exit),
                .start              (d_start[g]),
                .recal              (op == `FDHC_OP_RECAL),
                .target             (pwdata[15:8]),
                .step_rate_time                (srt_r),
                .track_zero_n       (track_zero_n[g]),
                .ack                (ack_r[g]),
                .step_r             (step_r[g]),
                .dir_r              (dir_r[g]),
                .present_cylinder_r (d_pcn[8*g +: 8]),
                .done_r             (d_done[g]),
                .seek_end_r         (d_se[g]),
                .equip_chk_r        (d_ec[g]),
                .busy_r             (d_busy[g])
            );
        end
    endgenerate

    // Lowest drive with a pending seek-end interrupt
    reg       pend_any;
    reg [1:0] pend_drv;
    integer   k;
    always @* begin
        pend_any = 1'b0;
        pend_drv = 2'b00;
        for (k = 3; k >= 0; k = k - 1) begin
            if (d_done[k]) begin
                pend_any = 1'b1;
                pend_drv = k[1:0];
            end
        end
    end

    wire [7:0] sel_pcn = d_pcn[8*pend_drv +: 8];
    wire       idx_fall = idx_prev_r & ~index_pulse_n;

    // Command interpreter, read-id search and interrupt causes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srt_r       <= 4'h0;
            st0_r       <= 8'h00;
            res_byte_r  <= 8'h00;
            idreg_r     <= 32'h00000000;
            ma_r        <= 1'b0;
            ri_state_r  <= RI_IDLE;
            idx_cnt_r   <= 2'b00;
            idx_prev_r  <= 1'b1;
            xfer_pend_r <= 1'b0;
            poll_pend_r <= 1'b1;
            cmd_busy_r  <= 1'b0;
            ack_r       <= 4'h0;
            drive_r     <= 2'b00;
        end else begin
            idx_prev_r <= index_pulse_n;
            ack_r      <= 4'h0;
            // busy lasts only the command phase
            cmd_busy_r <= (ri_state_r == RI_WAIT);
            if (wr_acc & (paddr == `FDHC_OFS_SRT))
                srt_r <= pwdata[3:0];
            // result phase of a transfer command
            if (xfer_result)
                xfer_pend_r <= 1'b1;
            if (cmd_wr) begin
                case (op)
                    `FDHC_OP_SEEK, `FDHC_OP_RECAL: begin
                        cmd_busy_r <= 1'b1;
                    end
                    `FDHC_OP_READ_ID: begin
                        if (ri_state_r == RI_IDLE) begin
                            cmd_busy_r <= 1'b1;
                            ri_state_r <= RI_WAIT;
                            idx_cnt_r  <= 2'b00;
                            ma_r       <= 1'b0;
                            drive_r    <= dsel;
                        end
                    end
                    `FDHC_OP_SENSE_INT: begin
                        // report cause and clear one source
                        if (pend_any) begin
                            st0_r <= {d_ec[pend_drv] ? `FDHC_IC_ABNORMAL
                                                     : `FDHC_IC_NORMAL,
                                      d_se[pend_drv], d_ec[pend_drv],
                                      1'b0, 1'b0, pend_drv};
                            res_byte_r <= sel_pcn;
                            ack_r[pend_drv] <= 1'b1;
                        end else if (poll_pend_r) begin
                            st0_r       <= {`FDHC_IC_POLL, 6'h00};
                            res_byte_r  <= 8'h00;
                            poll_pend_r <= 1'b0;
                        end else if (xfer_pend_r & ~xfer_result) begin
                            xfer_pend_r <= 1'b0;
                        end else begin
                            st0_r <= {`FDHC_IC_INVALID, 6'h00};
                        end
                    end
                    `FDHC_OP_SENSE_DRV: begin
                        res_byte_r <= {1'b0, ~write_prot_n, 1'b1,
                                       track_zero_n[dsel], 1'b1,
                                       pwdata[16], dsel};
                    end
                    default: st0_r <= {`FDHC_IC_INVALID, 6'h00};
                endcase
            end
            if (ri_state_r == RI_WAIT) begin
                if (id_valid) begin
                    idreg_r     <= id_field;
                    st0_r       <= {`FDHC_IC_NORMAL, 4'h0, drive_r};
                    xfer_pend_r <= 1'b1;
                    ri_state_r  <= RI_IDLE;
                end else if (idx_fall & (idx_cnt_r == 2'b01)) begin
                    st0_r       <= {`FDHC_IC_ABNORMAL, 4'h0, drive_r};
                    ma_r        <= 1'b1;
                    xfer_pend_r <= 1'b1;
                    ri_state_r  <= RI_IDLE;
                end else if (idx_fall) begin
                    idx_cnt_r <= idx_cnt_r + 2'b01;
                end
            end
            if (pd_exit) begin
                st0_r       <= 8'h00;
                res_byte_r  <= 8'h00;
                ma_r        <= 1'b0;
                xfer_pend_r <= 1'b0;
            end
        end
    end

    // interrupt from seek ends, read-id and transfer results, and the reset poll
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fdc_int_r <= 1'b0;
        else
            fdc_int_r <= pend_any | xfer_pend_r | poll_pend_r;
    end

    // Format preamble sequencer: segment index and repeat count
    reg  [3:0] seg_r;
    reg  [6:0] rep_r;
    reg        fmt_on_r;
    reg        ddam_r;
    reg  [7:0] seg_byte;
    reg  [6:0] seg_len;

    always @* begin
        case (seg_r)
            4'd0:    begin seg_byte = `FDHC_GAP_BYTE;  seg_len = `FDHC_GAP4A_CNT; end
            4'd1:    begin seg_byte = `FDHC_SYNC_BYTE; seg_len = `FDHC_SYNC_CNT;  end
            4'd2:    begin seg_byte = `FDHC_IAM_BYTE;  seg_len = 7'h01;           end
            4'd3:    begin seg_byte = `FDHC_GAP_BYTE;  seg_len = `FDHC_GAP1_CNT;  end
            4'd4:    begin seg_byte = `FDHC_SYNC_BYTE; seg_len = `FDHC_SYNC_CNT;  end
            4'd5:    begin seg_byte = `FDHC_IDENTIFIER_ADDRESS_MARK_BYTE; seg_len = 7'h01;           end
            4'd6:    begin seg_byte = idreg_r[31:24];  seg_len = 7'h01;           end
            4'd7:    begin seg_byte = idreg_r[23:16];  seg_len = 7'h01;           end
            4'd8:    begin seg_byte = idreg_r[15:8];   seg_len = 7'h01;           end
            4'd9:    begin seg_byte = idreg_r[7:0];    seg_len = 7'h01;           end
            4'd10:   begin seg_byte = `FDHC_GAP_BYTE;  seg_len = `FDHC_GAP2_CNT;  end
            4'd11:   begin seg_byte = `FDHC_SYNC_BYTE; seg_len = `FDHC_SYNC_CNT;  end
            default: begin
                seg_byte = ddam_r ? `FDHC_DDAM_BYTE : `FDHC_DAM_BYTE;
                seg_len  = 7'h01;
            end
        endcase
    end

    // Bytes advance only when the drive side takes them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_r       <= 4'd0;
            rep_r       <= 7'h00;
            fmt_on_r    <= 1'b0;
            ddam_r      <= 1'b0;
            fmt_byte_r  <= 8'h00;
            fmt_valid_r <= 1'b0;
        end else if (!fmt_on_r) begin
            // Last byte stands until the drive side takes it
            if (fmt_ready)
                fmt_valid_r <= 1'b0;
            if (fmt_start) begin
                fmt_on_r <= 1'b1;
                ddam_r   <= fmt_deleted;
                seg_r    <= 4'd0;
                rep_r    <= 7'h00;
            end
        end else if (!fmt_valid_r | fmt_ready) begin
            fmt_byte_r  <= seg_byte;
            fmt_valid_r <= 1'b1;
            if (rep_r + 7'h01 == seg_len) begin
                rep_r <= 7'h00;
                if (seg_r == 4'd12)
                    fmt_on_r <= 1'b0;
                else
                    seg_r <= seg_r + 4'd1;
            end else begin
                rep_r <= rep_r + 7'h01;
            end
        end
    end

    // APB answer: ready in the access cycle, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= psel & ~penable;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
            if (psel & ~penable) begin
                case (paddr)
                    `FDHC_OFS_CMD:    prdata_r <= 32'h00000000;
                    `FDHC_OFS_SRT:    prdata_r <= {28'h0000000, srt_r};
                    `FDHC_OFS_STATUS: prdata_r <= {22'h000000, ma_r,
                                                   fdc_int_r, d_busy,
                                                   3'b000, cmd_busy_r};
                    `FDHC_OFS_RESULT: prdata_r <= {16'h0000, res_byte_r,
                                                   st0_r};
                    `FDHC_OFS_IDREG:  prdata_r <= idreg_r;
                    default:          pslverr_r <= 1'b1;
                endcase
            end
        end
    end
endmodule // fdhc_top

`default_nettype wire

/* File: tb_disk_head_control_commands.sv */
// Self-checking bench for the head control block
`timescale 1ns/1ps
`default_nettype none
module tb_disk_head_control_commands;
    logic        pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, id_field = 32'h01020304;
    logic        index_pulse_n = 1, id_valid = 0, pd_exit = 0;
    logic        fmt_start = 0, fmt_ready = 0, xfer_result = 0;
    wire  [31:0] prdata_r;
    wire         pready_r, pslverr_r, fmt_valid_r, fdc_int_r;
    wire  [7:0]  fmt_byte_r;
    wire  [3:0]  track_zero_n, step_r, dir_r;
    int          errors = 0, n_compared = 0, i;
    fdhc_top #(.STEP_UNIT_CYC(4)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
        .pslverr_r(pslverr_r), .track_zero_n(track_zero_n),
        .index_pulse_n(index_pulse_n), .write_prot_n(1'b1),
        .id_valid(id_valid), .id_field(id_field), .xfer_result(xfer_result),
        .pd_exit(pd_exit), .fmt_start(fmt_start), .fmt_deleted(1'b0),
        .fmt_ready(fmt_ready), .fmt_byte_r(fmt_byte_r),
        .fmt_valid_r(fmt_valid_r), .step_r(step_r), .dir_r(dir_r),
        .fdc_int_r(fdc_int_r));
    fdhc_drive_model drv (.pclk(pclk), .step_r(step_r), .dir_r(dir_r),
        .track_zero_n(track_zero_n));
    // Free-running 25 MHz clock
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("Error t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    // One transfer; holds the request until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready_r !== 1'b1);
        rd = prdata_r;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // sense interrupt after each seek, then fetch the result word
    task automatic sense();
        apb(1, 8'h00, 32'h8);
        apb(0, 8'h0c, 32'h0);
    endtask
    task automatic wait_int();
        for (int k = 0; k < 5000 && fdc_int_r !== 1'b1; k++) @(posedge pclk);
        chk(fdc_int_r, 1'b1);
    endtask
    function automatic logic [7:0] fx(int k);
        return k < 40 ? 8'hff : k < 46 ? 8'h00 : k == 46 ? 8'hfc :
               k < 73 ? 8'hff : k < 79 ? 8'h00 : k == 79 ? 8'hfe :
               k < 84 ? id_field[8*(83-k) +: 8] : k < 95 ? 8'hff :
               k < 101 ? 8'h00 : 8'hfb;
    endfunction
    task automatic finish_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Watchdog: the sequence needs well under 20000 cycles
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(1, 8'h04, 32'hf);
        apb(0, 8'h04, 32'h0);
        chk(rd[3:0], 4'hf);
        sense();
        chk(rd[7:0], 8'hc0);
        apb(0, 8'h08, 32'h0);
        chk(rd[8], 1'b0);
        apb(0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        apb(1, 8'h00, 32'h7);
        apb(0, 8'h08, 32'h0);
        chk(rd[4:0], 5'h10);
        wait_int();
        sense();
        chk(rd[15:0], 16'h0020);
        apb(1, 8'h00, 32'h050f);
        wait_int();
        sense();
        chk(rd[15:0], 16'h0520);
        chk(drv.hp[0], 5);
        apb(1, 8'h00, 32'h020f);
        wait_int();
        sense();
        chk(rd[15:0], 16'h0220);
        chk(drv.hp[0], 2);
        pd_exit <= 1;
        @(posedge pclk);
        pd_exit <= 0;
        apb(1, 8'h00, 32'h010f);
        wait_int();
        sense();
        chk(rd[15:0], 16'h0120);
        chk(drv.hp[0], 3);
        apb(1, 8'h00, 32'h0017);
        wait_int();
        apb(0, 8'h08, 32'h0);
        chk(rd[5], 1'b1);
        sense();
        chk(rd[7:0], 8'h71);
        chk(drv.nst[1], 79);
        apb(1, 8'h00, 32'h4);
        apb(0, 8'h0c, 32'h0);
        chk(rd[15:8] & 8'hbf, 8'h28);
        chk(fdc_int_r, 1'b0);
        // seek and sense done, read-id captures the id field
        apb(1, 8'h00, 32'ha);
        id_valid <= 1;
        @(posedge pclk);
        id_valid <= 0;
        wait_int();
        apb(0, 8'h10, 32'h0);
        chk(rd, 32'h01020304);
        sense();
        apb(1, 8'h00, 32'ha);
        repeat (2) begin
            index_pulse_n <= 0;
            @(posedge pclk);
            index_pulse_n <= 1;
            repeat (3) @(posedge pclk);
        end
        wait_int();
        apb(0, 8'h08, 32'h0);
        chk(rd[9], 1'b1);
        sense();
        chk(rd[7:0], 8'h40);
        xfer_result <= 1;
        @(posedge pclk);
        xfer_result <= 0;
        wait_int();
        sense();
        apb(0, 8'h08, 32'h0);
        chk(rd[8], 1'b0);
        // gaps are fixed here; host gap lengths unused
        fmt_start <= 1;
        @(posedge pclk);
        fmt_start <= 0;
        // Consumer stalls every other cycle
        i = 0;
        while (i < 102) begin
            fmt_ready <= ~fmt_ready;
            @(posedge pclk);
            if (fmt_valid_r && fmt_ready) begin
                chk(fmt_byte_r, fx(i));
                i++;
            end
        end
        finish_test();
    end
endmodule // tb_disk_head_control_commands
`default_nettype wire
